// >>> rtl/ctb_map.svh
// Purpose: Register offsets, field positions and reset values of the transmit buffer handler.
// Assumes: APB byte addresses, one register per aligned 32-bit word, byte data in bits 7:0.
// Notes: Definitions only.
`ifndef CTB_MAP_SVH
`define CTB_MAP_SVH

// ================================================================
// Address map
`define CTB_BUF_STRIDE 12'h040
`define CTB_BUF_WORDS 4'he
`define CTB_BUF_COUNT 2'h3
`define CTB_BUF_END 12'h0c0
`define CTB_REG_INT_EN 12'h100
`define CTB_REG_INT_FLAG 12'h104
`define CTB_REG_CTRL 12'h108
`define CTB_REG_PIN_CTRL 12'h10c
`define CTB_REG_SEND_CMD 12'h110

// ================================================================
// Field positions of tx_buffer_control
`define CTB_TXC_ABORTED 6
`define CTB_TXC_LOST 5
`define CTB_TXC_ERR 4
`define CTB_TXC_PEND 3
`define CTB_TXC_PRIO_HI 1
`define CTB_TXC_PRIO_LO 0

// ================================================================
// Field positions of the flag, enable, control and pin registers
`define CTB_INT_MERR 7
`define CTB_CTRL_ABORT_ALL 4
`define CTB_CTRL_ONE_SHOT 3
`define CTB_PIN_STATE_LO 3

// ================================================================
// Reset values
`define CTB_RST_BYTE 8'h00
`define CTB_RST_PIN_CTRL 3'h0
`define CTB_RST_PIN_LEVEL 3'h7

`endif

// >>> rtl/ctb_pkg.sv
// Purpose: Types shared by the transmit buffer handler.
// Assumes: Nothing beyond the map header.
// Notes: Holds types only; numbers live in ctb_map.svh.
package ctb_pkg;
	typedef enum logic {CTB_IDLE, CTB_BUSY} ctb_state_e;
	typedef logic [1:0] ctb_prio_t;
	typedef logic [1:0] ctb_idx_t;
endpackage

// >>> rtl/ctb_tx_handler.sv
// Purpose: Transmit buffer handler of a CAN controller: three buffers, priority choice, aborts.
// Assumes: APB master on one side, protocol engine with pulse results on the other.
// Notes: Single clock, synchronous active-high reset, zero-wait APB with registered read data.
//
// Summary of operation
// - Three transmit buffers, fourteen bytes each, all in the register map.
// - Each buffer is one control byte, five identifier bytes, eight payload bytes.
// - At each frame start the highest priority pending buffer is sent.
// - Equal priorities go to the larger buffer index first.
// - Two-bit priority per buffer, three highest, zero lowest.
// - Pending set by control write, send command register, or request pin.
// - A control write sets pending and priority together.
// - Setting pending clears aborted, lost arbitration and error flags.
// - Transmission starts only once the engine reports the bus idle.
// - Success clears pending, sets completion flag, interrupt when enabled.
// - Error keeps pending, sets buffer error and message error flags.
// - Lost arbitration sets its flag and keeps pending for retry.
// - One-shot keeps failure flags but clears pending, no retry.
// - Request pins are send inputs or plain inputs; changed only in configuration.
// - A falling edge on an enabled request pin sets that buffer pending.
// - Clearing pending aborts one buffer without setting its aborted flag.
// - Abort-all requests abort of all pending buffers until host clears it.
// - Aborted flag is set only by abort-all or one-shot failure.
// - A frame on the bus finishes; abort acts only if it then fails.
// - One-shot failure by error or lost arbitration sets the aborted flag.
`timescale 1ns/100ps
`include "ctb_map.svh"

module ctb_tx_handler #(
	parameter int NBUF = 3
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// APB slave
	input wire logic [11:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Device pins and mode
	input wire logic [NBUF-1:0] send_request_pin_n_i,
	input wire logic cfg_mode_i,
	output logic int_n_o,
	// Protocol engine
	input wire logic bus_idle_i,
	output logic tx_start_o,
	output ctb_pkg::ctb_idx_t tx_buf_o,
	input wire logic [3:0] eng_rd_idx_i,
	output logic [7:0] eng_rd_data_o,
	input wire logic tx_ok_i,
	input wire logic tx_lost_i,
	input wire logic tx_err_i
);

	// ================================================================
	// Decoding helpers

	// Flat storage index of identifier and payload byte w (1..13) of buffer b.
	function automatic logic [5:0] mem_index(input logic [1:0] b, input logic [3:0] w);
		logic [5:0] base;
		base = 6'(b) * 6'd13;
		return 6'(base + 6'(w) - 6'd1);
	endfunction

	// True when the address falls inside a transmit buffer.
	function automatic logic in_buf(input logic [11:0] a);
		return (a < `CTB_BUF_END) && (a[5:2] < `CTB_BUF_WORDS) && (a[1:0] == 2'h0);
	endfunction

	// Buffer with the highest priority; later index wins ties.
	function automatic logic [1:0] pick_best(input logic [NBUF-1:0] pend,
			input logic [2*NBUF-1:0] pr);
		logic [1:0] best;
		logic [1:0] bp;
		logic found;
		best = 2'h0;
		bp = 2'h0;
		found = 1'b0;
		for (int i = 0; i < NBUF; i++) begin
			if (pend[i] && (!found || pr[2*i +: 2] >= bp)) begin
				best = 2'(i);
				bp = pr[2*i +: 2];
				found = 1'b1;
			end
		end
		return best;
	endfunction

	// ================================================================
	// State

	logic [7:0] msg_mem [0:13*NBUF-1];
	logic [NBUF-1:0] pending;
	logic [NBUF-1:0] aborted;
	logic [NBUF-1:0] lost_arb;
	logic [NBUF-1:0] tx_error;
	logic [2*NBUF-1:0] prio;
	logic [NBUF-1:0] tx_if;
	logic [NBUF-1:0] tx_ie;
	logic merr_flag;
	logic merr_en;
	logic one_shot;
	logic abort_all;
	logic [NBUF-1:0] pin_en;
	logic [NBUF-1:0] pin_s1;
	logic [NBUF-1:0] pin_s2;
	logic [NBUF-1:0] pin_s3;
	ctb_pkg::ctb_state_e state;

	// ================================================================
	// APB decode

	logic access;
	logic wr_en;
	logic buf_hit;
	logic [1:0] buf_sel;
	logic [3:0] word_sel;
	logic reg_hit;
	logic [NBUF-1:0] ctrl_wr;
	logic cmd_wr;

	assign buf_sel = paddr_i[7:6];
	assign word_sel = paddr_i[5:2];
	assign buf_hit = in_buf(paddr_i);
	assign reg_hit = (paddr_i == `CTB_REG_INT_EN) || (paddr_i == `CTB_REG_INT_FLAG) ||
		(paddr_i == `CTB_REG_CTRL) || (paddr_i == `CTB_REG_PIN_CTRL) ||
		(paddr_i == `CTB_REG_SEND_CMD);
	assign access = psel_i && penable_i;
	// Writes land only on the access edge; byte lane 0 carries every register.
	assign wr_en = access && pwrite_i && pstrb_i[0] && (buf_hit || reg_hit);
	assign cmd_wr = wr_en && (paddr_i == `CTB_REG_SEND_CMD);
	assign pready_o = 1'b1;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pslverr_o <= 1'b0;
		end else if (psel_i && !penable_i) begin
			pslverr_o <= !(buf_hit || reg_hit);
		end
	end

	// ================================================================
	// Request pin synchronisers

	logic [NBUF-1:0] pin_fall;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pin_s1 <= `CTB_RST_PIN_LEVEL;
			pin_s2 <= `CTB_RST_PIN_LEVEL;
			pin_s3 <= `CTB_RST_PIN_LEVEL;
		end else begin
			pin_s1 <= send_request_pin_n_i;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	assign pin_fall = pin_s3 & ~pin_s2 & pin_en;

	// ================================================================
	// Scheduler

	logic launch;
	logic busy;
	logic result;
	logic fail;
	logic [1:0] best;

	assign busy = (state == ctb_pkg::CTB_BUSY);
	assign result = busy && (tx_ok_i || tx_lost_i || tx_err_i);
	assign fail = busy && (tx_lost_i || tx_err_i);
	assign best = pick_best(pending, prio);
	// Pending only marks readiness; the frame waits for an idle bus.
	assign launch = !busy && bus_idle_i && (|pending) && !abort_all;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state <= ctb_pkg::CTB_IDLE;
			tx_start_o <= 1'b0;
			tx_buf_o <= 2'h0;
		end else begin
			tx_start_o <= launch;
			unique case (state)
				ctb_pkg::CTB_IDLE: begin
					if (launch) begin
						state <= ctb_pkg::CTB_BUSY;
						tx_buf_o <= best;
					end
				end
				ctb_pkg::CTB_BUSY: begin
					// An abort never cuts a frame short; only its result ends it.
					if (result) begin
						state <= ctb_pkg::CTB_IDLE;
					end
				end
			endcase
		end
	end

	// ================================================================
	// Per-buffer control bytes

	logic [NBUF-1:0] set_req;

	genvar g;
	generate
		for (g = 0; g < NBUF; g++) begin : g_buf
			logic in_flight;
			logic give_up;
			logic glob_abort;
			logic clr_req;

			assign ctrl_wr[g] = wr_en && buf_hit && (buf_sel == 2'(g)) && (word_sel == 4'h0);
			assign set_req[g] = (ctrl_wr[g] && pwdata_i[`CTB_TXC_PEND]) ||
				(cmd_wr && pwdata_i[g]) || pin_fall[g];
			assign in_flight = busy && (tx_buf_o == 2'(g));
			assign give_up = in_flight && fail && (one_shot || abort_all);
			assign glob_abort = abort_all && pending[g] && !in_flight;
			assign clr_req = (ctrl_wr[g] && !pwdata_i[`CTB_TXC_PEND]) ||
				(in_flight && tx_ok_i) || give_up || glob_abort;

			always_ff @(posedge sys_clk_i) begin
				if (rst_i) begin
					pending[g] <= 1'b0;
				end else if (set_req[g]) begin
					pending[g] <= 1'b1;
				end else if (clr_req) begin
					pending[g] <= 1'b0;
				end
			end

			always_ff @(posedge sys_clk_i) begin
				if (rst_i) begin
					prio[2*g +: 2] <= 2'h0;
				end else if (ctrl_wr[g]) begin
					prio[2*g +: 2] <= pwdata_i[`CTB_TXC_PRIO_HI:`CTB_TXC_PRIO_LO];
				end
			end

			// A failure reported in the same cycle as a new request still shows.
			always_ff @(posedge sys_clk_i) begin
				if (rst_i) begin
					aborted[g] <= 1'b0;
					lost_arb[g] <= 1'b0;
					tx_error[g] <= 1'b0;
				end else begin
					if (give_up || glob_abort) begin
						aborted[g] <= 1'b1;
					end else if (set_req[g]) begin
						aborted[g] <= 1'b0;
					end
					if (in_flight && tx_lost_i) begin
						lost_arb[g] <= 1'b1;
					end else if (set_req[g]) begin
						lost_arb[g] <= 1'b0;
					end
					if (in_flight && tx_err_i) begin
						tx_error[g] <= 1'b1;
					end else if (set_req[g]) begin
						tx_error[g] <= 1'b0;
					end
				end
			end

			always_ff @(posedge sys_clk_i) begin
				if (rst_i) begin
					tx_if[g] <= 1'b0;
				end else begin
					tx_if[g] <= (in_flight && tx_ok_i) ||
						(tx_if[g] && !(wr_en && (paddr_i == `CTB_REG_INT_FLAG) &&
						!pwdata_i[g]));
				end
			end
		end
	endgenerate

	// ================================================================
	// Message storage

	always_ff @(posedge sys_clk_i) begin
		if (wr_en && buf_hit && (word_sel != 4'h0)) begin
			msg_mem[mem_index(buf_sel, word_sel)] <= pwdata_i[7:0];
		end
	end

	// The engine names a byte 1..13 of the buffer it is sending.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			eng_rd_data_o <= `CTB_RST_BYTE;
		end else if (eng_rd_idx_i != 4'h0 && eng_rd_idx_i < `CTB_BUF_WORDS) begin
			eng_rd_data_o <= msg_mem[mem_index(tx_buf_o, eng_rd_idx_i)];
		end else begin
			eng_rd_data_o <= `CTB_RST_BYTE;
		end
	end

	// ================================================================
	// Global registers and interrupt pin

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tx_ie <= '0;
			merr_en <= 1'b0;
		end else if (wr_en && (paddr_i == `CTB_REG_INT_EN)) begin
			tx_ie <= pwdata_i[NBUF-1:0];
			merr_en <= pwdata_i[`CTB_INT_MERR];
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			merr_flag <= 1'b0;
		end else if (busy && tx_err_i) begin
			merr_flag <= 1'b1;
		end else if (wr_en && (paddr_i == `CTB_REG_INT_FLAG) && !pwdata_i[`CTB_INT_MERR]) begin
			merr_flag <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			one_shot <= 1'b0;
			abort_all <= 1'b0;
		end else if (wr_en && (paddr_i == `CTB_REG_CTRL)) begin
			one_shot <= pwdata_i[`CTB_CTRL_ONE_SHOT];
			abort_all <= pwdata_i[`CTB_CTRL_ABORT_ALL];
		end
	end

	// Pin roles may only change in configuration mode; other writes are dropped.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pin_en <= `CTB_RST_PIN_CTRL;
		end else if (wr_en && (paddr_i == `CTB_REG_PIN_CTRL) && cfg_mode_i) begin
			pin_en <= pwdata_i[NBUF-1:0];
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			int_n_o <= 1'b1;
		end else begin
			int_n_o <= !(|(tx_if & tx_ie) || (merr_flag && merr_en));
		end
	end

	// ================================================================
	// Read data, captured in the setup cycle

	logic [31:0] next_rdata;

	always_comb begin
		next_rdata = '0;
		if (buf_hit && word_sel == 4'h0 && buf_sel < `CTB_BUF_COUNT) begin
			next_rdata[`CTB_TXC_ABORTED] = aborted[buf_sel];
			next_rdata[`CTB_TXC_LOST] = lost_arb[buf_sel];
			next_rdata[`CTB_TXC_ERR] = tx_error[buf_sel];
			next_rdata[`CTB_TXC_PEND] = pending[buf_sel];
			next_rdata[`CTB_TXC_PRIO_HI:`CTB_TXC_PRIO_LO] = prio[2*buf_sel +: 2];
		end else if (buf_hit && buf_sel < `CTB_BUF_COUNT) begin
			next_rdata[7:0] = msg_mem[mem_index(buf_sel, word_sel)];
		end else if (paddr_i == `CTB_REG_INT_EN) begin
			next_rdata[NBUF-1:0] = tx_ie;
			next_rdata[`CTB_INT_MERR] = merr_en;
		end else if (paddr_i == `CTB_REG_INT_FLAG) begin
			next_rdata[NBUF-1:0] = tx_if;
			next_rdata[`CTB_INT_MERR] = merr_flag;
		end else if (paddr_i == `CTB_REG_CTRL) begin
			next_rdata[`CTB_CTRL_ONE_SHOT] = one_shot;
			next_rdata[`CTB_CTRL_ABORT_ALL] = abort_all;
		end else if (paddr_i == `CTB_REG_PIN_CTRL) begin
			next_rdata[NBUF-1:0] = pin_en;
			next_rdata[`CTB_PIN_STATE_LO +: NBUF] = pin_s2;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			prdata_o <= '0;
		end else if (psel_i && !penable_i) begin
			prdata_o <= next_rdata;
		end
	end

	// ================================================================
	// Assertions

	property p_success;
		@(posedge sys_clk_i) disable iff (rst_i)
		(busy && tx_ok_i && !set_req[tx_buf_o]) |=> (!pending[$past(tx_buf_o)] &&
			tx_if[$past(tx_buf_o)]);
	endproperty
	a_success: assert property (p_success) else $error("success did not retire buffer");

	property p_error_retry;
		@(posedge sys_clk_i) disable iff (rst_i)
		(busy && tx_err_i && !one_shot && !abort_all) |=> (pending[$past(tx_buf_o)] &&
			tx_error[$past(tx_buf_o)] && merr_flag);
	endproperty
	a_error_retry: assert property (p_error_retry) else $error("error flags wrong");

	property p_lost_retry;
		@(posedge sys_clk_i) disable iff (rst_i)
		(busy && tx_lost_i && !one_shot && !abort_all) |=> (pending[$past(tx_buf_o)] &&
			lost_arb[$past(tx_buf_o)] && !busy);
	endproperty
	a_lost_retry: assert property (p_lost_retry) else $error("lost arbitration not kept");

	property p_one_shot;
		@(posedge sys_clk_i) disable iff (rst_i)
		(fail && one_shot && !set_req[tx_buf_o]) |=> (!pending[$past(tx_buf_o)] &&
			aborted[$past(tx_buf_o)]);
	endproperty
	a_one_shot: assert property (p_one_shot) else $error("one-shot failure retried");

	property p_flag_clear;
		@(posedge sys_clk_i) disable iff (rst_i)
		(set_req[0] && !(busy && tx_buf_o == 2'h0)) |=> (pending[0] && !aborted[0] &&
			!lost_arb[0] && !tx_error[0]);
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("stale flags on request");

	property p_tie_break;
		@(posedge sys_clk_i) disable iff (rst_i)
		(launch && pending[2] && prio[5:4] >= prio[3:2] && prio[5:4] >= prio[1:0]) |=>
			(tx_start_o && tx_buf_o == 2'h2);
	endproperty
	a_tie_break: assert property (p_tie_break) else $error("tie not to larger index");

	property p_highest;
		@(posedge sys_clk_i) disable iff (rst_i)
		(launch && pending[0] && prio[1:0] > prio[3:2] && prio[1:0] > prio[5:4]) |=>
			(tx_buf_o == 2'h0);
	endproperty
	a_highest: assert property (p_highest) else $error("higher priority not chosen");

	property p_bus_idle;
		@(posedge sys_clk_i) disable iff (rst_i)
		tx_start_o |-> ($past(bus_idle_i) && !$past(abort_all) && busy);
	endproperty
	a_bus_idle: assert property (p_bus_idle) else $error("start without idle bus");

	property p_pin_edge;
		@(posedge sys_clk_i) disable iff (rst_i)
		(pin_en[0] && $fell(pin_s2[0])) |=> pending[0];
	endproperty
	a_pin_edge: assert property (p_pin_edge) else $error("pin edge lost");

	property p_abort_cause;
		@(posedge sys_clk_i) disable iff (rst_i)
		$rose(aborted[1]) |-> ($past(abort_all) || $past(one_shot));
	endproperty
	a_abort_cause: assert property (p_abort_cause) else $error("aborted flag without cause");

	property p_frame_runs;
		@(posedge sys_clk_i) disable iff (rst_i)
		(busy && abort_all && !result) |=> busy;
	endproperty
	a_frame_runs: assert property (p_frame_runs) else $error("frame cut by abort");

endmodule

// >>> test/ctb_engine_model.sv
// Purpose: Behavioural protocol engine facing the transmit buffer handler.
// Assumes: One start pulse opens a frame; one result pulse closes it.
// Notes: Result kind 0 success, 1 lost arbitration, 2 error; delay counts cycles.
`timescale 1ns/100ps

module ctb_engine_model (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Handler side
	input wire logic tx_start_i,
	input wire logic [7:0] eng_rd_data_i,
	output logic [3:0] eng_rd_idx_o,
	output logic tx_ok_o,
	output logic tx_lost_o,
	output logic tx_err_o,
	// Bench control and capture
	input wire logic [1:0] kind_i,
	input wire logic [7:0] delay_i,
	input wire logic [3:0] sel_i,
	output logic [7:0] cap_o
);
	logic busy;
	logic [7:0] cnt;

	// ================================================================
	// Frame sequencing
	always_ff @(posedge sys_clk_i) begin
		tx_ok_o <= 1'b0;
		tx_lost_o <= 1'b0;
		tx_err_o <= 1'b0;
		if (rst_i) begin
			busy <= 1'b0;
			cnt <= 8'h00;
			eng_rd_idx_o <= 4'h0;
			cap_o <= 8'h00;
		end else if (tx_start_i) begin
			busy <= 1'b1;
			cnt <= delay_i;
			eng_rd_idx_o <= sel_i;
		end else if (busy) begin
			cap_o <= eng_rd_data_i;
			// An abort never cuts a frame short; only the result ends it.
			if (cnt == 8'h00) begin
				busy <= 1'b0;
				eng_rd_idx_o <= ~eng_rd_idx_o;
				tx_ok_o <= kind_i == 2'h0;
				tx_lost_o <= kind_i == 2'h1;
				tx_err_o <= kind_i == 2'h2;
			end else begin
				cnt <= cnt - 8'h01;
			end
		end
	end
endmodule

// >>> test/ctb_tx_handler_tb.sv
// Purpose: Self-checking bench of the transmit buffer handler.
// Assumes: Engine model answers each start with one result pulse.
// Notes: The reference copy of the sent buffer's control byte is checked after each result.
`timescale 1ns/100ps
`include "ctb_map.svh"

module ctb_tx_handler_tb;
	logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, cfg, int_n, bus_idle;
	logic tx_start, ok, lost, err, rerr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdv, seed;
	logic [3:0] pstrb, idx, sel;
	logic [2:0] pins;
	logic [7:0] rd_data, cap, delay;
	logic [1:0] kind;
	ctb_pkg::ctb_idx_t tx_buf;
	int err_count = 0, comparisons = 0, starts = 0, s, cur_b, os = 0, abt = 0, e_if = 0;
	int e_ctl[3];
	logic [7:0] mem[3][14];

	ctb_tx_handler dut (.sys_clk_i(sys_clk), .rst_i(rst), .paddr_i(paddr), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(pstrb),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.send_request_pin_n_i(pins), .cfg_mode_i(cfg), .int_n_o(int_n),
		.bus_idle_i(bus_idle), .tx_start_o(tx_start), .tx_buf_o(tx_buf),
		.eng_rd_idx_i(idx), .eng_rd_data_o(rd_data), .tx_ok_i(ok), .tx_lost_i(lost),
		.tx_err_i(err));
	ctb_engine_model eng (.sys_clk_i(sys_clk), .rst_i(rst), .tx_start_i(tx_start),
		.eng_rd_data_i(rd_data), .eng_rd_idx_o(idx), .tx_ok_o(ok), .tx_lost_o(lost),
		.tx_err_o(err), .kind_i(kind), .delay_i(delay), .sel_i(sel), .cap_o(cap));

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) if (tx_start === 1'b1) starts++;

	// ================================================================
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Ascending scan with >= lets the larger index win a tie.
	function automatic int choose();
		int b = -1;
		for (int i = 0; i < 3; i++)
			if (e_ctl[i][3] && (b < 0 || e_ctl[i][1:0] >= e_ctl[b][1:0])) b = i;
		return b;
	endfunction
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		i = 0;
		@(posedge sys_clk);
		while (pready !== 1'b1) begin
			i++;
			if (i > 20) begin
				chk("pready", 1, 0);
				results();
			end
			@(posedge sys_clk);
		end
		rdv = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk_ctl(input int b);
		apb(1'b0, 12'(b * `CTB_BUF_STRIDE), 0);
		chk("control", e_ctl[b], rdv);
	endtask
	task automatic wctl(input int b, input logic [7:0] v);
		apb(1'b1, 12'(b * `CTB_BUF_STRIDE), {24'h0, v});
		if (v[3]) e_ctl[b] = 8'h08 | (v & 8'h03);
		else e_ctl[b] = (e_ctl[b] & 8'h70) | (v & 8'h03);
	endtask
	task automatic cmd(input int b);
		apb(1'b1, `CTB_REG_SEND_CMD, 32'h1 << b);
		e_ctl[b] = 8'h08 | (e_ctl[b] & 8'h03);
	endtask
	task automatic start_frame(input logic [1:0] k, input logic [7:0] dl);
		int i;
		kind <= k;
		delay <= dl;
		sel <= 4'(1 + seed % 13);
		seed = lfsr(seed);
		@(posedge sys_clk);
		bus_idle <= 1'b1;
		for (i = 0; i < 50 && tx_start !== 1'b1; i++) @(posedge sys_clk);
		if (i == 50) begin
			chk("start", 1, 0);
			results();
		end
		bus_idle <= 1'b0;
		cur_b = choose();
		chk("buffer", cur_b, tx_buf);
	endtask
	task automatic end_frame();
		int i;
		for (i = 0; i < 300 && (ok | lost | err) !== 1'b1; i++) @(posedge sys_clk);
		if (i == 300) begin
			chk("result", 1, 0);
			results();
		end
		chk("payload", mem[cur_b][sel], cap);
		if (ok) begin
			e_ctl[cur_b] &= 8'hf7;
			e_if |= 1 << cur_b;
		end else begin
			e_ctl[cur_b] |= lost ? 8'h20 : 8'h10;
			if (err) e_if |= 8'h80;
			if (os || abt) e_ctl[cur_b] = (e_ctl[cur_b] & 8'h77) | 8'h40;
		end
		repeat (3) @(posedge sys_clk);
		chk("int_n", (e_if & 8'h87) == 0, int_n);
		chk_ctl(cur_b);
		apb(1'b0, `CTB_REG_INT_FLAG, 0);
		chk("flags", e_if, rdv);
	endtask
	task automatic clr_flags();
		apb(1'b1, `CTB_REG_INT_FLAG, 0);
		e_if = 0;
	endtask

	// ================================================================
	// Main sequence
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, cfg, bus_idle} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hf;
		pins = 3'h7;
		kind = 2'h0;
		delay = 8'h08;
		sel = 4'h1;
		seed = 32'h033621de;
		e_ctl = '{0, 0, 0};
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		for (int b = 0; b < 3; b++) chk_ctl(b);
		chk("int_n", 1, int_n);
		apb(1'b0, `CTB_REG_PIN_CTRL, 0);
		chk("pin_ctrl", 32'h38, rdv);
		apb(1'b0, 12'h200, 0);
		chk("slverr", 1, rerr);
		chk("unmapped", 0, rdv);
		for (int b = 0; b < 3; b++)
			for (int w = 1; w < 14; w++) begin
				mem[b][w] = seed[7:0];
				seed = lfsr(seed);
				apb(1'b1, 12'(b * `CTB_BUF_STRIDE + 4 * w), {24'h0, mem[b][w]});
			end
		for (int b = 0; b < 3; b++)
			for (int w = 1; w < 14; w++) begin
				apb(1'b0, 12'(b * `CTB_BUF_STRIDE + 4 * w), 0);
				chk("byte", mem[b][w], rdv);
			end
		apb(1'b1, `CTB_REG_INT_EN, 32'h87);
		// Round zero ties all priorities, round one puts buffer 0 on top, the rest are random.
		for (int r = 0; r < 5; r++) begin
			s = starts;
			for (int b = 0; b < 3; b++)
				wctl(b, r == 0 ? 8'h0a : r == 1 ? (b == 0 ? 8'h0b : 8'h08) :
					8'h08 | seed[2*b +: 2]);
			seed = lfsr(seed);
			repeat (4) @(posedge sys_clk);
			chk("idle_hold", s, starts);
			for (int f = 0; f < 3; f++) begin
				start_frame(2'h0, 8'h06);
				end_frame();
			end
			clr_flags();
		end
		cmd(1);
		start_frame(2'h2, 8'h06);
		end_frame();
		wctl(1, 8'h0b);
		chk_ctl(1);
		start_frame(2'h1, 8'h06);
		end_frame();
		start_frame(2'h0, 8'h06);
		end_frame();
		clr_flags();
		apb(1'b1, `CTB_REG_CTRL, 32'h08);
		os = 1;
		for (int k = 1; k < 3; k++) begin
			cmd(0);
			start_frame(2'(k), 8'h06);
			end_frame();
		end
		apb(1'b1, `CTB_REG_CTRL, 32'h00);
		os = 0;
		wctl(2, 8'h09);
		wctl(2, 8'h01);
		chk_ctl(2);
		// Pin control written outside configuration must not take.
		apb(1'b1, `CTB_REG_PIN_CTRL, 32'h01);
		pins <= 3'h6;
		repeat (6) @(posedge sys_clk);
		chk_ctl(0);
		pins <= 3'h7;
		cfg <= 1'b1;
		apb(1'b1, `CTB_REG_PIN_CTRL, 32'h01);
		apb(1'b0, `CTB_REG_PIN_CTRL, 0);
		chk("pin_ctrl", 32'h39, rdv);
		s = starts;
		pins <= 3'h6;
		repeat (6) @(posedge sys_clk);
		e_ctl[0] = 8'h08 | (e_ctl[0] & 8'h03);
		chk_ctl(0);
		start_frame(2'h0, 8'h06);
		end_frame();
		repeat (10) @(posedge sys_clk);
		chk_ctl(0);
		chk("pin_starts", s + 1, starts);
		pins <= 3'h7;
		clr_flags();
		cmd(0);
		cmd(1);
		wctl(2, 8'h0b);
		start_frame(2'h1, 8'h3c);
		apb(1'b1, `CTB_REG_CTRL, 32'h10);
		abt = 1;
		for (int b = 0; b < 3; b++)
			if (b != cur_b && e_ctl[b][3]) e_ctl[b] = 8'h40 | (e_ctl[b] & 8'h03);
		for (int b = 0; b < 3; b++) chk_ctl(b);
		end_frame();
		apb(1'b1, `CTB_REG_CTRL, 32'h00);
		abt = 0;
		cmd(1);
		start_frame(2'h0, 8'h06);
		end_frame();
		results();
	end
endmodule
